// file: bench/cpu_bus_model.sv
// cpu core model driving the internal i/o bus
`timescale 1ns/1ps
module cpu_bus_model (
    // clock
    input wire logic i_sys_clk,
    // i/o bus
    input wire logic [7:0] i_io_rdata,
    output logic [7:0] o_io_addr,
    output logic [7:0] o_io_wdata,
    output logic o_io_we,
    output logic o_io_re
);
    initial begin
        o_io_addr = 8'h00;
        o_io_wdata = 8'h00;
        o_io_we = 1'b0;
        o_io_re = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_io_addr = a;
        o_io_wdata = d;
        o_io_we = 1'b1;
        @(negedge i_sys_clk);
        o_io_we = 1'b0;
        // released data never repeats the last byte
        o_io_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_io_addr = a;
        o_io_re = 1'b1;
        @(negedge i_sys_clk);
        o_io_re = 1'b0;
        d = i_io_rdata;
    endtask : rd
    // high byte first, the low write commits both
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    // low first, so the capture high byte comes from the latched temp
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask : rd16
endmodule : cpu_bus_model

// file: bench/testbench.sv
// self-checking bench for the timer compare, capture and irq block
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } row_s;
    logic i_sys_clk, i_resetn, i_io_we, i_io_re, i_timer_tick;
    logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, d;
    logic [15:0] i_counter_value, o_compare_a_value, o_compare_b_value;
    logic [15:0] o_capture_value, v;
    logic i_counter_write, i_counter_at_top, i_counter_overflow;
    logic [3:0] i_wave_mode_select;
    logic i_force_match_a_strobe, i_force_match_b_strobe, i_capture_pin;
    logic i_capture_rising_edge, i_global_irq_enable, o_top_from_capture;
    logic i_vector_ack_capture, i_vector_ack_match_b, i_vector_ack_match_a;
    logic i_vector_ack_overflow, o_irq_req_capture, o_irq_req_match_b;
    logic o_irq_req_match_a, o_irq_req_overflow, o_match_a, o_match_b;
    int error_cnt = 0;
    int n_checks = 0;
    row_s rows [5] = '{'{timer16_pkg::ADDR_MASK, 8'hff, 8'h27},
        '{timer16_pkg::ADDR_MASK, 8'h00, 8'h00}, '{8'h50, 8'hff, 8'h00},
        '{timer16_pkg::ADDR_FLAGS, 8'hff, 8'h00},
        '{timer16_pkg::ADDR_CMP_B_LO, 8'h5a, 8'h5a}};
    cpu_bus_model cpu (.i_sys_clk, .i_io_rdata(o_io_rdata),
        .o_io_addr(i_io_addr), .o_io_wdata(i_io_wdata),
        .o_io_we(i_io_we), .o_io_re(i_io_re));
    timer16_compare_capture_irq uut (.i_sys_clk, .i_resetn, .i_io_addr,
        .i_io_wdata, .i_io_we, .i_io_re, .o_io_rdata, .i_counter_value,
        .i_timer_tick, .i_counter_write, .i_counter_at_top,
        .i_counter_overflow, .i_wave_mode_select, .i_force_match_a_strobe,
        .i_force_match_b_strobe, .i_capture_noise_cancel(1'b0),
        .i_capture_rising_edge, .i_capture_use_comparator(1'b0),
        .i_capture_pin, .i_comparator_out(1'b0), .i_global_irq_enable,
        .i_vector_ack_capture, .i_vector_ack_match_b, .i_vector_ack_match_a,
        .i_vector_ack_overflow, .o_irq_req_capture, .o_irq_req_match_b,
        .o_irq_req_match_a, .o_irq_req_overflow, .o_match_a, .o_match_b,
        .o_compare_a_value, .o_compare_b_value, .o_capture_value,
        .o_top_from_capture);
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input string n, input logic [15:0] got,
                       input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge i_sys_clk);
        s = 1'b1;
        @(negedge i_sys_clk);
        s = 1'b0;
    endtask : pulse
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {i_timer_tick, i_counter_write, i_counter_at_top} = '0;
        {i_force_match_a_strobe, i_force_match_b_strobe} = '0;
        {i_vector_ack_capture, i_vector_ack_match_b, i_resetn} = '0;
        {i_vector_ack_match_a, i_vector_ack_overflow} = '0;
        {i_counter_overflow, i_capture_pin} = '0;
        i_wave_mode_select = 4'h0;
        i_counter_value = 16'h0000;
        {i_capture_rising_edge, i_global_irq_enable} = 2'b11;
        repeat (16) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        cpu.rd(timer16_pkg::ADDR_FLAGS, d);
        chk("flags", {8'h00, d}, 16'h0000);
        foreach (rows[i]) begin
            cpu.wr(rows[i].a, rows[i].w);
            cpu.rd(rows[i].a, d);
            chk("reg", {8'h00, d}, {8'h00, rows[i].r});
        end
        $display("test registers done");
        cpu.wr(timer16_pkg::ADDR_MASK, 8'hff);
        for (int ch = 0; ch < 2; ch++) begin
            v = 16'h1234 + 16'(ch);
            cpu.wr16(ch ? timer16_pkg::ADDR_CMP_B_LO :
                     timer16_pkg::ADDR_CMP_A_LO, v);
            chk("cmp", ch ? o_compare_b_value : o_compare_a_value, v);
            i_counter_value = v;
            pulse(i_timer_tick);
            chk("match", {15'h0, ch ? o_match_b : o_match_a}, 16'h1);
            // a zero write must leave the flag alone
            cpu.wr(timer16_pkg::ADDR_FLAGS, 8'h00);
            chk("req", {15'h0, ch ? o_irq_req_match_b : o_irq_req_match_a},
                16'h1);
            if (ch == 0) begin
                pulse(i_vector_ack_match_a);
            end else begin
                cpu.wr(timer16_pkg::ADDR_FLAGS, 8'h04);
            end
            chk("clr", {15'h0, o_irq_req_match_a | o_irq_req_match_b},
                16'h0);
        end
        $display("test matches done");
        i_counter_value = 16'h1234;
        pulse(i_counter_write);
        pulse(i_timer_tick);
        chk("blocked", {15'h0, o_irq_req_match_a}, 16'h0);
        pulse(i_timer_tick);
        chk("unblocked", {15'h0, o_irq_req_match_a}, 16'h1);
        pulse(i_vector_ack_match_a);
        i_counter_value = 16'h0000;
        pulse(i_force_match_a_strobe);
        chk("force", {15'h0, o_match_a}, 16'h1);
        pulse(i_force_match_b_strobe);
        chk("noflag", {14'h0, o_irq_req_match_a, o_irq_req_match_b},
            16'h0);
        $display("test blocking and force done");
        pulse(i_counter_overflow);
        chk("ovf", {15'h0, o_irq_req_overflow}, 16'h1);
        i_global_irq_enable = 1'b0;
        #1;
        chk("gie", {15'h0, o_irq_req_overflow}, 16'h0);
        i_global_irq_enable = 1'b1;
        pulse(i_vector_ack_overflow);
        chk("ovfclr", {15'h0, o_irq_req_overflow}, 16'h0);
        $display("test overflow done");
        i_counter_value = 16'hbeef;
        i_capture_pin = 1'b1;
        for (int k = 0; k < 20 && o_capture_value !== 16'hbeef; k++) begin
            @(negedge i_sys_clk);
        end
        if (o_capture_value !== 16'hbeef) begin
            error_cnt++;
            final_report();
        end
        cpu.rd16(timer16_pkg::ADDR_CAP_LO, v);
        chk("cap", v, 16'hbeef);
        chk("capreq", {15'h0, o_irq_req_capture}, 16'h1);
        cpu.wr(timer16_pkg::ADDR_FLAGS, 8'h20);
        $display("test capture done");
        i_wave_mode_select = 4'hc;
        i_capture_pin = 1'b0;
        repeat (8) @(negedge i_sys_clk);
        chk("top", {15'h0, o_top_from_capture}, 16'h1);
        i_counter_value = 16'h0001;
        i_capture_pin = 1'b1;
        repeat (8) @(negedge i_sys_clk);
        chk("nocap", o_capture_value, 16'hbeef);
        chk("noflag", {15'h0, o_irq_req_capture}, 16'h0);
        pulse(i_counter_at_top);
        chk("topflag", {15'h0, o_irq_req_capture}, 16'h1);
        pulse(i_vector_ack_capture);
        chk("capclr", {15'h0, o_irq_req_capture}, 16'h0);
        $display("test capture top done");
        final_report();
    end
endmodule : testbench

// file: bench/timer16_compare_capture_irq_sva.sv
// assertion checker for the timer compare, capture and irq block
`timescale 1ns/1ps
module timer16_cci_sva (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // inputs
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_io_we,
    input wire logic [15:0] i_counter_value,
    input wire logic i_timer_tick,
    input wire logic i_counter_write,
    input wire logic i_counter_overflow,
    input wire logic [3:0] i_wave_mode_select,
    input wire logic i_force_match_a_strobe,
    input wire logic i_global_irq_enable,
    input wire logic i_vector_ack_overflow,
    // outputs
    input wire logic o_irq_req_capture,
    input wire logic o_irq_req_match_b,
    input wire logic o_irq_req_match_a,
    input wire logic o_irq_req_overflow,
    input wire logic o_match_a,
    input wire logic o_match_b,
    input wire logic [15:0] o_compare_a_value,
    input wire logic [15:0] o_compare_b_value,
    input wire logic o_top_from_capture
);
    logic blk_ff;
    logic hit_a, hit_b, non_pwm, cap_top;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // a counter write arms a block that the next tick consumes
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            blk_ff <= 1'b0;
        end else if (i_timer_tick || i_counter_write) begin
            blk_ff <= i_counter_write;
        end
    end
    assign hit_a = i_timer_tick && !blk_ff &&
                   i_counter_value == o_compare_a_value;
    assign hit_b = i_timer_tick && !blk_ff &&
                   i_counter_value == o_compare_b_value;
    assign non_pwm = i_wave_mode_select inside {4'h0, 4'h4, 4'hc};
    assign cap_top = i_wave_mode_select inside {4'h8, 4'ha, 4'hc, 4'he};
    a_match_a_pulse: assert property (hit_a |=> o_match_a)
        else $error("match a missing");
    a_match_b_pulse: assert property (hit_b |=> o_match_b)
        else $error("match b missing");
    a_no_spur_a: assert property (o_match_a |->
        $past(hit_a) || $past(i_force_match_a_strobe && non_pwm))
        else $error("unexpected match a");
    a_irq_gated: assert property (!i_global_irq_enable |->
        !(o_irq_req_capture || o_irq_req_match_b ||
          o_irq_req_match_a || o_irq_req_overflow))
        else $error("irq without global enable");
    a_flags_reset: assert property ($rose(i_resetn) |->
        !(o_irq_req_capture || o_irq_req_match_b ||
          o_irq_req_match_a || o_irq_req_overflow))
        else $error("flag set after reset");
    a_top_mode: assert property ($past(i_resetn) |->
        o_top_from_capture == $past(cap_top))
        else $error("top source wrong");
    a_cmp_hi_wait: assert property (i_io_we &&
        i_io_addr == timer16_pkg::ADDR_CMP_A_HI |=> $stable(o_compare_a_value))
        else $error("compare changed on high byte");
    a_cmp_lo_commit: assert property (i_io_we &&
        i_io_addr == timer16_pkg::ADDR_CMP_A_LO |=>
        o_compare_a_value[7:0] == $past(i_io_wdata))
        else $error("compare low byte not committed");
    a_ovf_ack_clear: assert property (i_vector_ack_overflow &&
        !i_counter_overflow |=> !o_irq_req_overflow)
        else $error("overflow flag not cleared");
endmodule : timer16_cci_sva
bind timer16_compare_capture_irq timer16_cci_sva chk_i (.i_sys_clk,
    .i_resetn, .i_io_addr, .i_io_wdata, .i_io_we, .i_counter_value,
    .i_timer_tick, .i_counter_write, .i_counter_overflow,
    .i_wave_mode_select, .i_force_match_a_strobe, .i_global_irq_enable,
    .i_vector_ack_overflow, .o_irq_req_capture, .o_irq_req_match_b,
    .o_irq_req_match_a, .o_irq_req_overflow, .o_match_a, .o_match_b,
    .o_compare_a_value, .o_compare_b_value, .o_top_from_capture);

// file: shared/timer16_pkg.sv
// constants for the 16-bit timer compare, capture and interrupt block
package timer16_pkg;

    // register addresses on the internal i/o bus
    localparam logic [7:0] ADDR_FLAGS = 8'h36;
    localparam logic [7:0] ADDR_MASK = 8'h38;
    localparam logic [7:0] ADDR_CAP_LO = 8'h40;
    localparam logic [7:0] ADDR_CAP_HI = 8'h41;
    localparam logic [7:0] ADDR_CMP_A_LO = 8'h42;
    localparam logic [7:0] ADDR_CMP_A_HI = 8'h43;
    localparam logic [7:0] ADDR_CMP_B_LO = 8'h44;
    localparam logic [7:0] ADDR_CMP_B_HI = 8'h45;

    // bit positions shared by the mask and flag registers
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_MATCH_B = 2;
    localparam int BIT_CAPTURE = 5;
    localparam logic [7:0] USED_BITS = 8'h27;

    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

    // capture noise canceler needs this many equal samples
    localparam int NOISE_SAMPLES = 4;

    // waveform modes of interest
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PC_CAP = 4'ha;
    localparam logic [3:0] MODE_CTC_CAP = 4'hc;
    localparam logic [3:0] MODE_FAST_CAP = 4'he;

    // capture register serves as top in these modes
    function automatic logic capture_is_top(input logic [3:0] mode);
        capture_is_top = (mode == MODE_PFC_CAP) || (mode == MODE_PC_CAP) ||
                         (mode == MODE_CTC_CAP) || (mode == MODE_FAST_CAP);
    endfunction : capture_is_top

    // force strobes only act outside the pwm modes
    function automatic logic non_pwm_mode(input logic [3:0] mode);
        non_pwm_mode = (mode == MODE_NORMAL) || (mode == MODE_CTC_CMP) ||
                       (mode == MODE_CTC_CAP);
    endfunction : non_pwm_mode

endpackage : timer16_pkg

// file: verilog/capture_input_filter.sv
// capture source sync, noise canceler and edge detector
`timescale 1ns/1ps
module capture_input_filter #(
    parameter int SAMPLES = timer16_pkg::NOISE_SAMPLES
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // raw asynchronous sources
    input wire logic i_capture_pin,
    input wire logic i_comparator_out,
    // configuration
    input wire logic i_use_comparator,
    input wire logic i_noise_cancel,
    input wire logic i_rising_edge,
    // qualified event
    output logic o_capture_event
);

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [SAMPLES-1:0] hist;
        logic filt;
        logic event_p;
    } filt_s;

    filt_s st_ff;
    filt_s nxt_st;
    logic src;
    logic cand;

    always_comb begin
        nxt_st = st_ff;
        // first stage feeds only the second stage
        nxt_st.sync1 = {i_comparator_out, i_capture_pin};
        nxt_st.sync2 = st_ff.sync1;
        src = i_use_comparator ? st_ff.sync2[1] : st_ff.sync2[0];
        nxt_st.hist = {st_ff.hist[SAMPLES-2:0], src};
        cand = st_ff.filt;
        if (!i_noise_cancel) begin
            cand = src;
        end else if (&st_ff.hist) begin
            cand = 1'b1;
        end else if (~|st_ff.hist) begin
            cand = 1'b0;
        end
        nxt_st.filt = cand;
        nxt_st.event_p = i_rising_edge ? (cand & ~st_ff.filt)
                                       : (~cand & st_ff.filt);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_capture_event = st_ff.event_p;

endmodule : capture_input_filter

// file: verilog/timer16_compare_capture_irq.sv
// compare, capture and interrupt registers of the 16-bit timer
`timescale 1ns/1ps

module timer16_compare_capture_irq (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // internal i/o bus from the cpu core
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_io_we,
    input wire logic i_io_re,
    output logic [7:0] o_io_rdata,
    // counter unit
    input wire logic [15:0] i_counter_value,
    input wire logic i_timer_tick,
    input wire logic i_counter_write,
    input wire logic i_counter_at_top,
    input wire logic i_counter_overflow,
    // timer control
    input wire logic [3:0] i_wave_mode_select,
    input wire logic i_force_match_a_strobe,
    input wire logic i_force_match_b_strobe,
    input wire logic i_capture_noise_cancel,
    input wire logic i_capture_rising_edge,
    input wire logic i_capture_use_comparator,
    // capture sources
    input wire logic i_capture_pin,
    input wire logic i_comparator_out,
    // cpu interrupt side
    input wire logic i_global_irq_enable,
    input wire logic i_vector_ack_capture,
    input wire logic i_vector_ack_match_b,
    input wire logic i_vector_ack_match_a,
    input wire logic i_vector_ack_overflow,
    output logic o_irq_req_capture,
    output logic o_irq_req_match_b,
    output logic o_irq_req_match_a,
    output logic o_irq_req_overflow,
    // to waveform generator and counter
    output logic o_match_a,
    output logic o_match_b,
    output logic [15:0] o_compare_a_value,
    output logic [15:0] o_compare_b_value,
    output logic [15:0] o_capture_value,
    output logic o_top_from_capture
);

    typedef struct packed {
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] cap;
        logic [7:0] temp;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic block;
        logic match_a;
        logic match_b;
        logic cap_top;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    logic cap_event;
    logic cap_top;
    logic hit_a;
    logic hit_b;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] ack_v;
    logic wr_flags;

    capture_input_filter #(
        .SAMPLES(timer16_pkg::NOISE_SAMPLES)
    ) u_capture_filter (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_capture_pin(i_capture_pin),
        .i_comparator_out(i_comparator_out),
        .i_use_comparator(i_capture_use_comparator),
        .i_noise_cancel(i_capture_noise_cancel),
        .i_rising_edge(i_capture_rising_edge),
        .o_capture_event(cap_event)
    );

    always_comb begin
        nxt_st = st_ff;
        cap_top = timer16_pkg::capture_is_top(i_wave_mode_select);
        nxt_st.cap_top = cap_top;

        // a counter write kills the match on the next tick only
        if (i_counter_write) begin
            nxt_st.block = 1'b1;
        end else if (i_timer_tick) begin
            nxt_st.block = 1'b0;
        end

        hit_a = i_timer_tick && !st_ff.block &&
                (i_counter_value == st_ff.cmp_a);
        hit_b = i_timer_tick && !st_ff.block &&
                (i_counter_value == st_ff.cmp_b);

        // forced strobes reach the waveform side, never the flags
        nxt_st.match_a = hit_a || (i_force_match_a_strobe &&
                         timer16_pkg::non_pwm_mode(i_wave_mode_select));
        nxt_st.match_b = hit_b || (i_force_match_b_strobe &&
                         timer16_pkg::non_pwm_mode(i_wave_mode_select));

        set_v = timer16_pkg::BYTE_RESET;
        set_v[timer16_pkg::BIT_MATCH_A] = hit_a;
        set_v[timer16_pkg::BIT_MATCH_B] = hit_b;
        set_v[timer16_pkg::BIT_OVERFLOW] = i_counter_overflow;
        if (cap_top) begin
            // pin is cut off, flag marks top instead
            set_v[timer16_pkg::BIT_CAPTURE] = i_counter_at_top;
        end else begin
            set_v[timer16_pkg::BIT_CAPTURE] = cap_event;
        end

        // capture load; a cpu write in the same cycle loses
        if (cap_event && !cap_top) begin
            nxt_st.cap = i_counter_value;
        end

        ack_v = timer16_pkg::BYTE_RESET;
        ack_v[timer16_pkg::BIT_CAPTURE] = i_vector_ack_capture;
        ack_v[timer16_pkg::BIT_MATCH_B] = i_vector_ack_match_b;
        ack_v[timer16_pkg::BIT_MATCH_A] = i_vector_ack_match_a;
        ack_v[timer16_pkg::BIT_OVERFLOW] = i_vector_ack_overflow;
        wr_flags = i_io_we && (i_io_addr == timer16_pkg::ADDR_FLAGS);
        clr_v = ack_v | (wr_flags ? i_io_wdata
                                  : timer16_pkg::BYTE_RESET);
        // a set in the clearing cycle survives
        nxt_st.flags = ((st_ff.flags & ~clr_v) | set_v) &
                       timer16_pkg::USED_BITS;

        if (i_io_we) begin
            case (i_io_addr)
                timer16_pkg::ADDR_MASK: begin
                    nxt_st.mask = i_io_wdata & timer16_pkg::USED_BITS;
                end
                timer16_pkg::ADDR_CMP_A_HI,
                timer16_pkg::ADDR_CMP_B_HI,
                timer16_pkg::ADDR_CAP_HI: begin
                    nxt_st.temp = i_io_wdata;
                end
                timer16_pkg::ADDR_CMP_A_LO: begin
                    nxt_st.cmp_a = {st_ff.temp, i_io_wdata};
                end
                timer16_pkg::ADDR_CMP_B_LO: begin
                    nxt_st.cmp_b = {st_ff.temp, i_io_wdata};
                end
                timer16_pkg::ADDR_CAP_LO: begin
                    if (!(cap_event && !cap_top)) begin
                        nxt_st.cap = {st_ff.temp, i_io_wdata};
                    end
                end
                default: begin
                    nxt_st.temp = st_ff.temp;
                end
            endcase
        end

        // reads answer one cycle after the strobe
        if (i_io_re) begin
            case (i_io_addr)
                timer16_pkg::ADDR_FLAGS: begin
                    nxt_st.rdata = st_ff.flags;
                end
                timer16_pkg::ADDR_MASK: begin
                    nxt_st.rdata = st_ff.mask;
                end
                timer16_pkg::ADDR_CAP_LO: begin
                    nxt_st.rdata = st_ff.cap[7:0];
                    nxt_st.temp = st_ff.cap[15:8];
                end
                timer16_pkg::ADDR_CAP_HI: begin
                    nxt_st.rdata = st_ff.temp;
                end
                timer16_pkg::ADDR_CMP_A_LO: begin
                    nxt_st.rdata = st_ff.cmp_a[7:0];
                end
                timer16_pkg::ADDR_CMP_A_HI: begin
                    nxt_st.rdata = st_ff.cmp_a[15:8];
                end
                timer16_pkg::ADDR_CMP_B_LO: begin
                    nxt_st.rdata = st_ff.cmp_b[7:0];
                end
                timer16_pkg::ADDR_CMP_B_HI: begin
                    nxt_st.rdata = st_ff.cmp_b[15:8];
                end
                default: begin
                    nxt_st.rdata = timer16_pkg::BYTE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_ff.cmp_a <= timer16_pkg::VALUE_RESET;
            st_ff.cmp_b <= timer16_pkg::VALUE_RESET;
            st_ff.cap <= timer16_pkg::VALUE_RESET;
            st_ff.temp <= timer16_pkg::BYTE_RESET;
            st_ff.flags <= timer16_pkg::FLAGS_RESET;
            st_ff.mask <= timer16_pkg::MASK_RESET;
            st_ff.rdata <= timer16_pkg::BYTE_RESET;
            st_ff.block <= 1'b0;
            st_ff.match_a <= 1'b0;
            st_ff.match_b <= 1'b0;
            st_ff.cap_top <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // requests are levels; the core acks when it takes the vector
    assign o_irq_req_capture = i_global_irq_enable &&
        st_ff.flags[timer16_pkg::BIT_CAPTURE] &&
        st_ff.mask[timer16_pkg::BIT_CAPTURE];
    assign o_irq_req_match_b = i_global_irq_enable &&
        st_ff.flags[timer16_pkg::BIT_MATCH_B] &&
        st_ff.mask[timer16_pkg::BIT_MATCH_B];
    assign o_irq_req_match_a = i_global_irq_enable &&
        st_ff.flags[timer16_pkg::BIT_MATCH_A] &&
        st_ff.mask[timer16_pkg::BIT_MATCH_A];
    assign o_irq_req_overflow = i_global_irq_enable &&
        st_ff.flags[timer16_pkg::BIT_OVERFLOW] &&
        st_ff.mask[timer16_pkg::BIT_OVERFLOW];

    assign o_io_rdata = st_ff.rdata;
    assign o_match_a = st_ff.match_a;
    assign o_match_b = st_ff.match_b;
    assign o_compare_a_value = st_ff.cmp_a;
    assign o_compare_b_value = st_ff.cmp_b;
    assign o_capture_value = st_ff.cap;
    assign o_top_from_capture = st_ff.cap_top;

endmodule : timer16_compare_capture_irq
